// file: logic/bafe_misc_regs.sv
`timescale 1ns/1ns
// Overview of operation
// RQ1: Negative lead status bit per channel reads 1 when detached, 0 when connected.
// RQ2: Port data bits at 14h read back the real pin levels in either direction.
// RQ3: Writing a port data bit drives the pin only when it is an output.
// RQ4: Direction bit 0 means output, 1 input; port register resets to 0Fh.
// RQ5: Pacing select bits 2:1 pick channel 1 for x0 and channel 2 for x1.
// RQ6: Pacing enable bit 0 turns the pacing circuit off at 0, on at 1.
// RQ7: Pacing register bit 5 connects the first shared reference pin when set.
// RQ8: Host writes zeros into pacing register bits 7:6.
// RQ9: Breathing bit 7 switches channel 1 demodulation on when set.
// RQ10: Breathing bit 6 switches channel 1 modulation on when set.
// RQ11: Phase field 4:2 picks 22.5 degree steps; code 111 unused.
// RQ12: Mode field 1:0 selects none, external, internal, internal with user signals.
// RQ13: Frequency code 000 gives 64kHz and 001 gives 32kHz modulation clock.
// RQ14: Frequency codes 010 to 111 put a halving square wave on port pin 1.
// RQ15: In internal mode the modulation signals appear on both modulation outputs.
// RQ16: Conversion register bit 3 selects continuous at 0, single shot at 1.
// RQ17: Conversion register bit 1 enables the lead comparator when set.
// RQ18: While breathing mode is active channel 1 delivers no signal samples.
// RQ19: Host ignores a lead status bit whose sense enable is not set.
// RQ20: Writes to the lead status register change nothing.
module bafe_misc_regs #(
	parameter int WAVE_BASE_HALF = bafe_pkg::MOD_HALF_CYCLES
) (
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	input  wire bafe_pkg::bafe_req_t req_i,
	output logic [7:0]               rdata_o,
	output logic                     rvalid_o,
	input  wire logic [1:0]          neg_detach_i,
	input  wire logic [1:0]          port_pin_i,
	output logic [1:0]               port_pin_o,
	output logic [1:0]               port_oe_o,
	output bafe_pkg::bafe_ctl_t      ctl_o,
	output logic                     breath_mod_out_pos_o,
	output logic                     breath_mod_out_neg_o,
	output logic                     ch1_samples_on_o
);

	// ==========================================================
	// State.
	typedef struct packed {
		logic [7:0] general_io_port;
		logic [1:0] port_latch;
		logic [7:0] pacing_select;
		logic [7:0] breathing_control;
		logic [7:0] conversion_setup;
		logic [7:0] rdata;
		logic       rvalid;
	} bafe_regs_state_t;

	bafe_regs_state_t st;
	bafe_regs_state_t next_st;

	logic [1:0] pin_level;
	logic [1:0] detach_sync;
	logic [1:0] negative_lead_status;
	logic [1:0] port_dir;
	logic [2:0] breath_frequency;
	logic [1:0] breath_mode;
	logic       breath_mod_on;
	logic       wave;
	logic       wave_run;
	logic       pin_wave_on;
	logic       mod_wave_on;
	logic [7:0] port_read;

	// ==========================================================
	// Input synchronisers.
	bafe_sync #(
		.W (4)
	) u_sync (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.async_i ({neg_detach_i, port_pin_i}),
		.sync_o  ({detach_sync, pin_level})
	);

	// ==========================================================
	// Field decode.
	assign port_dir         = st.general_io_port[bafe_pkg::POS_PORT_DIR_HI:
	                                             bafe_pkg::POS_PORT_DIR_LO];
	assign breath_frequency = st.conversion_setup[bafe_pkg::POS_BREATH_FREQ +: 3];
	assign breath_mode      = st.breathing_control[bafe_pkg::POS_BREATH_MODE +: 2];
	assign breath_mod_on    = st.breathing_control[bafe_pkg::POS_BREATH_MOD];

	// Lead status follows the comparator only while it is powered.
	assign negative_lead_status = detach_sync &
		{2{st.conversion_setup[bafe_pkg::POS_LEAD_COMP]}}; // RQ1 RQ17

	// Port register read merges pin levels into the data field.
	always_comb begin
		port_read = st.general_io_port;
		port_read[bafe_pkg::POS_PORT_DATA_HI:bafe_pkg::POS_PORT_DATA_LO] = pin_level; // RQ2
	end

	// ==========================================================
	// Register writes and reads.
	always_comb begin
		next_st        = st;
		next_st.rvalid = req_i.rd;
		if (req_i.wr) begin
			if (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) begin
				next_st.general_io_port = req_i.wdata;
				next_st.general_io_port[bafe_pkg::POS_PORT_DATA_HI:
				                        bafe_pkg::POS_PORT_DATA_LO] = 2'h0;
				for (int i = 0; i < 2; i++) begin
					if (!port_dir[i]) begin
						next_st.port_latch[i] = req_i.wdata[bafe_pkg::POS_PORT_DATA_LO + i]; // RQ3
					end
				end
			end else if (req_i.addr == bafe_pkg::OFS_PACING_SELECT) begin
				next_st.pacing_select = req_i.wdata;
			end else if (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) begin
				next_st.breathing_control = req_i.wdata;
			end else if (req_i.addr == bafe_pkg::OFS_CONVERSION_SET) begin
				next_st.conversion_setup = req_i.wdata;
			end
			// The lead status offset holds no storage, so a write there is dropped.
		end
		if (req_i.rd) begin
			if (req_i.addr == bafe_pkg::OFS_NEG_LEAD_STATUS) begin
				next_st.rdata = {6'h00, negative_lead_status}; // RQ1 RQ20
			end else if (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) begin
				next_st.rdata = port_read; // RQ2
			end else if (req_i.addr == bafe_pkg::OFS_PACING_SELECT) begin
				next_st.rdata = st.pacing_select;
			end else if (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) begin
				next_st.rdata = st.breathing_control;
			end else if (req_i.addr == bafe_pkg::OFS_CONVERSION_SET) begin
				next_st.rdata = st.conversion_setup;
			end else begin
				next_st.rdata = 8'h00;
			end
		end
		if (!nrst_i) begin
			next_st.general_io_port   = bafe_pkg::RST_GENERAL_IO_PORT; // RQ4
			next_st.port_latch        = bafe_pkg::RST_PORT_LATCH;
			next_st.pacing_select     = bafe_pkg::RST_PACING_SELECT;
			next_st.breathing_control = bafe_pkg::RST_BREATHING_CTRL;
			next_st.conversion_setup  = bafe_pkg::RST_CONVERSION_SET;
			next_st.rdata             = 8'h00;
			next_st.rvalid            = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign rdata_o  = st.rdata;
	assign rvalid_o = st.rvalid;

	// ==========================================================
	// Modulation clock and port square wave.
	assign pin_wave_on = (breath_frequency >= bafe_pkg::FREQ_FIRST_PIN) &&
	                     (breath_mode != bafe_pkg::BREATH_NONE); // RQ14
	assign mod_wave_on = (breath_frequency < bafe_pkg::FREQ_FIRST_PIN) && breath_mod_on &&
	                     breath_mode[1]; // RQ13 RQ15
	assign wave_run    = pin_wave_on || mod_wave_on;

	bafe_wave_gen u_wave (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.run_i       (wave_run),
		.code_i      (breath_frequency),
		.base_half_i (WAVE_BASE_HALF[bafe_pkg::WAVE_CNT_W-1:0]),
		.wave_o      (wave)
	);

	assign breath_mod_out_pos_o = mod_wave_on & wave; // RQ15
	assign breath_mod_out_neg_o = mod_wave_on & ~wave; // RQ15

	// ==========================================================
	// Port pins.
	assign port_oe_o[1]  = ~port_dir[1]; // RQ4
	assign port_pin_o[1] = st.port_latch[1]; // RQ3
	assign port_oe_o[0]  = ~port_dir[0] | pin_wave_on; // RQ4 RQ14
	assign port_pin_o[0] = pin_wave_on ? wave : st.port_latch[0]; // RQ14

	// ==========================================================
	// Control outputs.
	assign ctl_o.pacing_circuit_on     = st.pacing_select[bafe_pkg::POS_PACING_ON]; // RQ6
	assign ctl_o.pacing_channel_choice = st.pacing_select[bafe_pkg::POS_PACING_CHOICE]; // RQ5
	assign ctl_o.shared_ref_pin_one    = st.pacing_select[bafe_pkg::POS_SHARED_REF]; // RQ7
	assign ctl_o.breath_demod_on       = st.breathing_control[bafe_pkg::POS_BREATH_DEMOD]; // RQ9
	assign ctl_o.breath_mod_on         = breath_mod_on; // RQ10
	assign ctl_o.breath_phase          = st.breathing_control[bafe_pkg::POS_BREATH_PHASE +: 3]; // RQ11
	assign ctl_o.breath_mode           = breath_mode; // RQ12
	assign ctl_o.single_shot           = st.conversion_setup[bafe_pkg::POS_SINGLE_SHOT]; // RQ16
	assign ctl_o.lead_comparator_on    = st.conversion_setup[bafe_pkg::POS_LEAD_COMP]; // RQ17
	assign ch1_samples_on_o            = (breath_mode == bafe_pkg::BREATH_NONE); // RQ18

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_lead_read;
		req_i.rd && (req_i.addr == bafe_pkg::OFS_NEG_LEAD_STATUS) |=>
			rvalid_o && (rdata_o == {6'h00, $past(detach_sync) &
			{2{$past(ctl_o.lead_comparator_on)}}});
	endproperty
	a_lead_read: assert property (p_lead_read) else $error("lead status read wrong"); // RQ1

	property p_port_read;
		req_i.rd && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) |=>
			rdata_o[5:4] == $past(pin_level);
	endproperty
	a_port_read: assert property (p_port_read) else $error("port read not pin level"); // RQ2

	property p_input_write;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) && port_dir[1] |=>
			$stable(port_pin_o[1]);
	endproperty
	a_input_write: assert property (p_input_write) else $error("input pin write took effect"); // RQ3

	property p_output_write;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) && !port_dir[1] |=>
			port_pin_o[1] == $past(req_i.wdata[5]);
	endproperty
	a_output_write: assert property (p_output_write) else $error("output pin write lost"); // RQ3

	property p_port_reset;
		disable iff (1'b0)
		!nrst_i |=> (port_oe_o == 2'h0) && (rdata_o == 8'h00) && !ctl_o.pacing_circuit_on;
	endproperty
	a_port_reset: assert property (p_port_reset) else $error("reset value wrong"); // RQ4

	property p_comp_off;
		!ctl_o.lead_comparator_on |-> negative_lead_status == 2'h0;
	endproperty
	a_comp_off: assert property (p_comp_off) else $error("status while comparator off"); // RQ17

	property p_mod_outputs;
		!(breath_mode[1] && breath_mod_on) |-> !breath_mod_out_pos_o && !breath_mod_out_neg_o;
	endproperty
	a_mod_outputs: assert property (p_mod_outputs) else $error("modulation outside internal"); // RQ15

	property p_ch1_busy;
		(breath_mode != bafe_pkg::BREATH_NONE) |-> !ch1_samples_on_o;
	endproperty
	a_ch1_busy: assert property (p_ch1_busy) else $error("channel 1 active in breathing"); // RQ18

	property p_pin_wave;
		pin_wave_on |-> port_oe_o[0] && (port_pin_o[0] == wave);
	endproperty
	a_pin_wave: assert property (p_pin_wave) else $error("square wave missing on pin 1"); // RQ14

	property p_status_write;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_NEG_LEAD_STATUS) |=>
			$stable(st.general_io_port) && $stable(st.conversion_setup);
	endproperty
	a_status_write: assert property (p_status_write) else $error("status write changed state"); // RQ20

	property p_pacing_on;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_PACING_SELECT) |=>
			ctl_o.pacing_circuit_on == $past(req_i.wdata[bafe_pkg::POS_PACING_ON]);
	endproperty
	a_pacing_on: assert property (p_pacing_on) else $error("pacing enable wrong"); // RQ6

	property p_pacing_choice;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_PACING_SELECT) |=>
			ctl_o.pacing_channel_choice == $past(req_i.wdata[bafe_pkg::POS_PACING_CHOICE]);
	endproperty
	a_pacing_choice: assert property (p_pacing_choice) else $error("pacing choice wrong"); // RQ5

	property p_shared_ref;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_PACING_SELECT) |=>
			ctl_o.shared_ref_pin_one == $past(req_i.wdata[bafe_pkg::POS_SHARED_REF]);
	endproperty
	a_shared_ref: assert property (p_shared_ref) else $error("shared reference wrong"); // RQ7

	property p_demod_on;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) |=>
			ctl_o.breath_demod_on == $past(req_i.wdata[bafe_pkg::POS_BREATH_DEMOD]);
	endproperty
	a_demod_on: assert property (p_demod_on) else $error("demodulation enable wrong"); // RQ9

	property p_mod_on;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) |=>
			ctl_o.breath_mod_on == $past(req_i.wdata[bafe_pkg::POS_BREATH_MOD]);
	endproperty
	a_mod_on: assert property (p_mod_on) else $error("modulation enable wrong"); // RQ10

	property p_phase;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) |=>
			ctl_o.breath_phase == $past(req_i.wdata[bafe_pkg::POS_BREATH_PHASE +: 3]);
	endproperty
	a_phase: assert property (p_phase) else $error("phase field wrong"); // RQ11

	property p_mode;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_BREATHING_CTRL) |=>
			ctl_o.breath_mode == $past(req_i.wdata[bafe_pkg::POS_BREATH_MODE +: 2]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode field wrong"); // RQ12

	property p_single_shot;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_CONVERSION_SET) |=>
			ctl_o.single_shot == $past(req_i.wdata[bafe_pkg::POS_SINGLE_SHOT]);
	endproperty
	a_single_shot: assert property (p_single_shot) else $error("conversion mode wrong"); // RQ16

	property p_lead_comp;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_CONVERSION_SET) |=>
			ctl_o.lead_comparator_on == $past(req_i.wdata[bafe_pkg::POS_LEAD_COMP]);
	endproperty
	a_lead_comp: assert property (p_lead_comp) else $error("comparator enable wrong"); // RQ17

	property p_port_dir;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) |=>
			port_oe_o[1] == !$past(req_i.wdata[bafe_pkg::POS_PORT_DIR_HI]);
	endproperty
	a_port_dir: assert property (p_port_dir) else $error("pin 2 direction wrong"); // RQ4

	property p_pin0_write;
		req_i.wr && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT) && !port_dir[0] &&
			!pin_wave_on |=> port_pin_o[0] == $past(req_i.wdata[bafe_pkg::POS_PORT_DATA_LO]);
	endproperty
	a_pin0_write: assert property (p_pin0_write) else $error("pin 1 output write lost"); // RQ3

	property p_mod_start;
		mod_wave_on && !$past(wave_run) |-> !breath_mod_out_pos_o && breath_mod_out_neg_o;
	endproperty
	a_mod_start: assert property (p_mod_start) else $error("modulation start level wrong"); // RQ13

	property p_ch1_free;
		(breath_mode == bafe_pkg::BREATH_NONE) |-> ch1_samples_on_o;
	endproperty
	a_ch1_free: assert property (p_ch1_free) else $error("channel 1 blocked without breathing"); // RQ18

	property p_unmapped_read;
		req_i.rd && ((req_i.addr < bafe_pkg::OFS_NEG_LEAD_STATUS) ||
			(req_i.addr > bafe_pkg::OFS_CONVERSION_SET)) |=> rdata_o == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	c_wave_toggle: cover property (pin_wave_on ##1 $changed(wave));
	c_mod_wave: cover property (mod_wave_on && breath_mod_out_pos_o);
	c_port_write: cover property (req_i.wr && (req_i.addr == bafe_pkg::OFS_GENERAL_IO_PORT));
	c_lead_seen: cover property (rvalid_o && (rdata_o[1:0] != 2'h0));
	c_status_write: cover property (req_i.wr && (req_i.addr == bafe_pkg::OFS_NEG_LEAD_STATUS));

endmodule

// file: logic/bafe_pkg.sv
package bafe_pkg;

	// ==========================================================
	// Register offsets.
	localparam logic [7:0] OFS_NEG_LEAD_STATUS = 8'h13;
	localparam logic [7:0] OFS_GENERAL_IO_PORT = 8'h14;
	localparam logic [7:0] OFS_PACING_SELECT   = 8'h15;
	localparam logic [7:0] OFS_BREATHING_CTRL  = 8'h16;
	localparam logic [7:0] OFS_CONVERSION_SET  = 8'h17;

	// ==========================================================
	// Reset values.
	localparam logic [7:0] RST_GENERAL_IO_PORT = 8'h0f;
	localparam logic [7:0] RST_PACING_SELECT   = 8'h00;
	localparam logic [7:0] RST_BREATHING_CTRL  = 8'h00;
	localparam logic [7:0] RST_CONVERSION_SET  = 8'h00;
	localparam logic [1:0] RST_PORT_LATCH      = 2'h0;

	// ==========================================================
	// Field positions.
	localparam int POS_PORT_DIR_LO   = 0;
	localparam int POS_PORT_DIR_HI   = 1;
	localparam int POS_PORT_DATA_LO  = 4;
	localparam int POS_PORT_DATA_HI  = 5;
	localparam int POS_PACING_ON     = 0;
	localparam int POS_PACING_CHOICE = 1;
	localparam int POS_SHARED_REF    = 5;
	localparam int POS_BREATH_MODE   = 0;
	localparam int POS_BREATH_PHASE  = 2;
	localparam int POS_BREATH_MOD    = 6;
	localparam int POS_BREATH_DEMOD  = 7;
	localparam int POS_LEAD_COMP     = 1;
	localparam int POS_SINGLE_SHOT   = 3;
	localparam int POS_BREATH_FREQ   = 5;

	// ==========================================================
	// Modes and codes.
	localparam logic [1:0] BREATH_NONE     = 2'h0;
	localparam logic [1:0] BREATH_EXTERNAL = 2'h1;
	localparam logic [2:0] FREQ_FIRST_PIN  = 3'h2;

	// ==========================================================
	// Timing.
	localparam int CLK_HZ          = 20000000;
	localparam int MOD_BASE_HZ     = 64000;
	localparam int MOD_HALF_CYCLES = CLK_HZ / (2 * MOD_BASE_HZ);
	localparam int WAVE_CNT_W      = 15;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bafe_req_t;

	typedef struct packed {
		logic       pacing_circuit_on;
		logic       pacing_channel_choice;
		logic       shared_ref_pin_one;
		logic       breath_demod_on;
		logic       breath_mod_on;
		logic [2:0] breath_phase;
		logic [1:0] breath_mode;
		logic       single_shot;
		logic       lead_comparator_on;
	} bafe_ctl_t;

endpackage

// file: logic/bafe_sync.sv
`timescale 1ns/1ns
module bafe_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ==========================================================
	// Two flip-flop synchroniser.
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} bafe_sync_state_t;

	bafe_sync_state_t st;
	bafe_sync_state_t next_st;

	always_comb begin
		next_st.first  = async_i;
		next_st.second = st.first;
		if (!nrst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign sync_o = st.second;

endmodule

// file: logic/bafe_wave_gen.sv
`timescale 1ns/1ns
module bafe_wave_gen (
	input  wire logic                           clk_i,
	input  wire logic                           nrst_i,
	input  wire logic                           run_i,
	input  wire logic [2:0]                     code_i,
	input  wire logic [bafe_pkg::WAVE_CNT_W-1:0] base_half_i,
	output logic                                wave_o
);

	// ==========================================================
	// Square wave whose half period doubles with each code step.
	typedef struct packed {
		logic [bafe_pkg::WAVE_CNT_W-1:0] cnt;
		logic [2:0]                      code;
		logic                            wave;
	} bafe_wave_state_t;

	bafe_wave_state_t                st;
	bafe_wave_state_t                next_st;
	logic [bafe_pkg::WAVE_CNT_W-1:0] half;

	assign half = base_half_i << code_i;

	always_comb begin
		next_st      = st;
		next_st.code = code_i;
		if (!run_i || (code_i != st.code)) begin
			next_st.cnt  = '0;
			next_st.wave = 1'b0;
		end else if (st.cnt >= half - 15'h0001) begin
			next_st.cnt  = '0;
			next_st.wave = ~st.wave;
		end else begin
			next_st.cnt = st.cnt + 15'h0001;
		end
		if (!nrst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign wave_o = st.wave;

endmodule

// file: bench/bafe_pin_model.sv
`timescale 1ns/1ns
module bafe_pin_model (
	input  wire logic [1:0] oe_i,
	input  wire logic [1:0] out_i,
	input  wire logic [1:0] ext_i,
	output logic      [1:0] pin_o
);
	// ==========================================================
	// Pin levels: the device drives where enabled, else the external source does.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_o[i] = oe_i[i] ? out_i[i] : ext_i[i];
		end
	end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
	logic                clk = 1'b0;
	logic                nrst_i = 1'b0;
	bafe_pkg::bafe_req_t req = '0;
	logic [1:0]          detach = 2'h0;
	logic [1:0]          ext = 2'h2;
	logic [1:0]          pin_lvl;
	logic [7:0]          rdata_o;
	logic                rvalid_o;
	logic [1:0]          port_pin_o;
	logic [1:0]          port_oe_o;
	bafe_pkg::bafe_ctl_t ctl_o;
	logic                mod_p;
	logic                mod_n;
	logic                ch1_on;
	int                  failures = 0;
	int                  n_tests = 0;

	always #25 clk = ~clk;

	bafe_misc_regs #(.WAVE_BASE_HALF(2)) dut (.clk_i(clk), .nrst_i(nrst_i), .req_i(req),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .neg_detach_i(detach), .port_pin_i(pin_lvl),
		.port_pin_o(port_pin_o), .port_oe_o(port_oe_o), .ctl_o(ctl_o),
		.breath_mod_out_pos_o(mod_p), .breath_mod_out_neg_o(mod_n), .ch1_samples_on_o(ch1_on));
	bafe_pin_model pins (.oe_i(port_oe_o), .out_i(port_pin_o), .ext_i(ext), .pin_o(pin_lvl));

	// ==========================================================
	// Shared tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin
			req.wr <= 1'b1;
			req.addr <= a;
			req.wdata <= d;
		end
		@(posedge clk) req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) begin
			req.rd <= 1'b1;
			req.addr <= a;
		end
		@(posedge clk) req.rd <= 1'b0;
		#1;
		check(rvalid_o, 1'b1);
		check(rdata_o, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic sig(input bit s);
		return s ? mod_p : port_pin_o[0];
	endfunction

	task automatic half(input bit s, input int exp);
		int   n;
		logic v;
		n = 0;
		v = sig(s);
		while (sig(s) === v && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		v = sig(s);
		n = 0;
		while (sig(s) === v && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n, exp);
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_reset;
		check(port_oe_o, 2'h0);
		check(ch1_on, 1'b1);
		rd(8'h14, 8'h2f);
		rd(8'h15, 8'h00);
		rd(8'h16, 8'h00);
		rd(8'h17, 8'h00);
		rd(8'h20, 8'h00);
	endtask

	task automatic t_status;
		wr(8'h17, 8'h02);
		check(ctl_o.lead_comparator_on, 1'b1);
		// Sense enables are taken as set, so every status bit is meaningful.
		@(posedge clk) detach <= 2'h1;
		settle();
		rd(8'h13, 8'h01);
		@(posedge clk) detach <= 2'h2;
		settle();
		rd(8'h13, 8'h02);
		wr(8'h13, 8'hff);
		settle();
		rd(8'h13, 8'h02);
		@(posedge clk) detach <= 2'h0;
		settle();
		rd(8'h13, 8'h00);
	endtask

	task automatic t_port;
		@(posedge clk) ext <= 2'h0;
		wr(8'h14, 8'h02);
		wr(8'h14, 8'h32);
		check(port_oe_o, 2'h1);
		check(port_pin_o, 2'h1);
		settle();
		rd(8'h14, 8'h12);
		@(posedge clk) ext <= 2'h2;
		settle();
		rd(8'h14, 8'h32);
		wr(8'h14, 8'h00);
		check(port_pin_o, 2'h0);
		wr(8'h14, 8'h20);
		check(port_oe_o, 2'h3);
		check(port_pin_o, 2'h2);
		settle();
		rd(8'h14, 8'h20);
		wr(8'h14, 8'h0f);
	endtask

	task automatic t_pacing;
		wr(8'h15, 8'h23);
		check(ctl_o.pacing_circuit_on, 1'b1);
		check(ctl_o.pacing_channel_choice, 1'b1);
		check(ctl_o.shared_ref_pin_one, 1'b1);
		wr(8'h15, 8'h04);
		check(ctl_o.pacing_circuit_on, 1'b0);
		check(ctl_o.pacing_channel_choice, 1'b0);
		check(ctl_o.shared_ref_pin_one, 1'b0);
		rd(8'h15, 8'h04);
	endtask

	task automatic t_breath;
		logic [7:0] v;
		for (int i = 0; i < 7; i++) begin
			v = {i[0], i[1], 1'b0, i[2:0], i[1:0]};
			wr(8'h16, v);
			check(ctl_o.breath_demod_on, i[0]);
			check(ctl_o.breath_mod_on, i[1]);
			check(ctl_o.breath_phase, i[2:0]);
			check(ctl_o.breath_mode, i[1:0]);
			check(ch1_on, i[1:0] == 2'h0);
			rd(8'h16, v);
		end
		wr(8'h17, 8'h0a);
		check(ctl_o.single_shot, 1'b1);
		check(ctl_o.lead_comparator_on, 1'b1);
		wr(8'h17, 8'h02);
		check(ctl_o.single_shot, 1'b0);
	endtask

	task automatic t_wave;
		wr(8'h16, 8'hc2);
		for (int c = 0; c < 2; c++) begin
			wr(8'h17, {c[2:0], 5'h02});
			half(1'b1, 2 << c);
			check(mod_n, !mod_p);
		end
		for (int c = 2; c < 8; c++) begin
			wr(8'h17, {c[2:0], 5'h02});
			half(1'b0, 2 << c);
			check(port_oe_o[0], 1'b1);
		end
		wr(8'h16, 8'h00);
		wr(8'h17, 8'h00);
		check(mod_p, 1'b0);
		check(port_oe_o, 2'h0);
	endtask

	// ==========================================================
	// Run control.
	task automatic test_done;
		$display("checks=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		failures++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge clk);
		nrst_i <= 1'b1;
		settle();
		#1;
		t_reset();
		t_status();
		t_port();
		t_pacing();
		t_breath();
		t_wave();
		test_done();
	end
endmodule
